//--- rtl/tws_slave.sv
// Two-wire slave front end presenting a memory target and a companion register target.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Start is SDA falling while SCL high.
// - Start abandons current transfer, expects new address.
// - Supply trip aborts; wait for next Start.
// - Stop is SDA rising; return to idle.
// - Ninth clock: transmitter releases, receiver pulls low.
// - Missing acknowledge ends operation, await addressing.
// - Reads continue while master acknowledges each byte.
// - First byte: ID, select bits, direction.
// - ID 1010b memory, 1101b companion registers.
// - Companion traffic never touches memory array.
// - Respond only when select bits match pins.
// - Direction bit one reads, zero writes.
// - Memory write sends upper then lower address.
// - Received address latched, kept until replaced or cleared by supply trip.
// - Companion access leaves memory address unchanged.
// - Reads start at current latched address.
// - Increment before acknowledge; wrap to zero.
// - Unlimited sequential bytes per transaction.
// - Companion address above 18h refused, aborted.
// - Bytes travel most significant bit first.

////////////////////////////////////////////////////////////////////////////////////////////////////

module tws_slave
   import tws_pkg::*;
#(
   parameter int MEM_AW = MEM_AW_DEF
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [1:0] sel_pins,
   input wire logic supply_low,
   input wire logic [7:0] comp_rdata,
   output logic comp_wr,
   output logic comp_rd,
   output logic [7:0] comp_addr,
   output logic [7:0] comp_wdata
);

   logic lrst_meta_reg;
   logic lrst_reg;
   logic [5:0] rst_cnt_reg;
   logic rst_hold_reg;
   logic [PIN_W-1:0] pin_q;
   logic scl_f;
   logic sda_f;
   logic trip_f;
   logic [1:0] sel_f;
   logic scl_p_reg;
   logic sda_p_reg;
   tws_state_t state_reg;
   tws_state_t nxt_reg;
   tws_state_t rx_next;
   logic [3:0] bit_cnt_reg;
   logic ack_ph_reg;
   logic ack_seen_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] hi_reg;
   logic [7:0] rd_buf_reg;
   logic sda_oe_reg;
   logic sda_out_reg;
   logic tgt_comp_reg;
   logic [MEM_AW-1:0] mem_addr_reg;
   logic [7:0] reg_addr_reg;
   logic req_tgl_reg;
   logic req_wr_reg;
   logic req_comp_reg;
   logic [REQ_AW-1:0] req_addr_reg;
   logic [7:0] req_data_reg;
   logic ack_q;
   logic ack_old_reg;
   logic ack_tgl;
   logic [7:0] rd_data;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Link-domain reset and pin capture.

   // A reset shorter than a link clock period is stretched so that the slow side still sees it.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rst_cnt_reg <= '0;
         rst_hold_reg <= 1'b1;
      end
      else if (rst_hold_reg)
      begin
         rst_cnt_reg <= rst_cnt_reg + 6'h01;
         rst_hold_reg <= !(&rst_cnt_reg);
      end
   end

   always_ff @(posedge link_clk)
   begin
      lrst_meta_reg <= rst_hold_reg;
      lrst_reg <= lrst_meta_reg;
   end

   tws_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_pin_sync
   (
      .clk(link_clk),
      .rst(lrst_reg),
      .d({supply_low, sel_pins, scl_in, sda_in}),
      .q(pin_q)
   );

   assign scl_f = pin_q[PIN_SCL];
   assign sda_f = pin_q[PIN_SDA];
   assign trip_f = pin_q[PIN_TRIP];
   assign sel_f = pin_q[PIN_SEL_HI:PIN_SEL_LO];

   always_ff @(posedge link_clk)
   begin
      if (lrst_reg)
      begin
         scl_p_reg <= 1'b1;
         sda_p_reg <= 1'b1;
      end
      else
      begin
         scl_p_reg <= scl_f;
         sda_p_reg <= sda_f;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Bus events and byte decoding.

   logic start_ev;
   logic stop_ev;
   logic rise_ev;
   logic fall_ev;
   logic in_tx;
   logic byte_done;
   logic ack_end;
   logic id_mem;
   logic id_comp;
   logic dev_hit;
   logic is_read;
   logic reg_ok;
   logic ack_ok;
   logic step_ev;
   logic wr_fire;
   logic rd_fire;
   logic use_comp;
   logic load_drive;
   logic [MEM_AW-1:0] mem_step;
   logic [7:0] reg_step;
   logic [MEM_AW-1:0] mem_req_addr;
   logic [7:0] reg_req_addr;
   logic [REQ_AW-1:0] req_addr_next;

   // Edges are judged on the filtered levels; the master owns SCL and this end never drives it.
   assign start_ev = scl_f && scl_p_reg && sda_p_reg && !sda_f;
   assign stop_ev = scl_f && scl_p_reg && !sda_p_reg && sda_f;
   assign rise_ev = scl_f && !scl_p_reg;
   assign fall_ev = !scl_f && scl_p_reg;
   assign in_tx = state_reg == ST_RDATA;
   assign byte_done = fall_ev && !ack_ph_reg && !trip_f && (bit_cnt_reg == BIT_LAST);
   assign ack_end = fall_ev && ack_ph_reg && !trip_f;

   assign id_mem = shift_reg[ID_HI:ID_LO] == ID_MEM;
   assign id_comp = shift_reg[ID_HI:ID_LO] == ID_COMP;
   assign dev_hit = (id_mem || id_comp) && (shift_reg[SEL_HI:SEL_LO] == sel_f);
   assign is_read = shift_reg[RW_BIT];
   assign reg_ok = shift_reg <= REG_LAST;

   assign ack_ok = (state_reg == ST_DEVADDR) ? dev_hit :
                   (state_reg == ST_REGADDR) ? reg_ok :
                   (state_reg inside {ST_MEMHI, ST_MEMLO, ST_WDATA});
   assign rx_next = !ack_ok ? ST_IDLE :
                    (state_reg == ST_DEVADDR) ? (is_read ? ST_RDATA :
                                                 (id_mem ? ST_MEMHI : ST_REGADDR)) :
                    (state_reg == ST_MEMHI) ? ST_MEMLO : ST_WDATA;

   assign step_ev = byte_done && (state_reg inside {ST_WDATA, ST_RDATA});
   assign wr_fire = byte_done && (state_reg == ST_WDATA);
   assign rd_fire = byte_done && (((state_reg == ST_DEVADDR) && dev_hit && is_read) || in_tx);
   assign use_comp = (state_reg == ST_DEVADDR) ? id_comp : tgt_comp_reg;
   assign mem_step = mem_addr_reg + 1'b1;
   assign reg_step = (reg_addr_reg == REG_LAST) ? REG_FIRST : reg_addr_reg + 8'h01;
   // A read fetches the following byte during the acknowledge of the current one.
   assign mem_req_addr = in_tx ? mem_step : mem_addr_reg;
   assign reg_req_addr = in_tx ? reg_step : reg_addr_reg;
   assign req_addr_next = use_comp ? REQ_AW'(reg_req_addr) : REQ_AW'(mem_req_addr);
   assign load_drive = in_tx ? ack_seen_reg : (nxt_reg == ST_RDATA);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   always_ff @(posedge link_clk)
   begin
      if (lrst_reg || trip_f || stop_ev)
      begin
         state_reg <= ST_IDLE;
         nxt_reg <= ST_IDLE;
         ack_ph_reg <= 1'b0;
         bit_cnt_reg <= '0;
      end
      else if (start_ev)
      begin
         state_reg <= ST_DEVADDR;
         ack_ph_reg <= 1'b0;
         bit_cnt_reg <= '0;
      end
      else if (rise_ev && !ack_ph_reg && (state_reg != ST_IDLE))
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      else if (byte_done)
      begin
         ack_ph_reg <= 1'b1;
         nxt_reg <= in_tx ? ST_RDATA : rx_next;
      end
      else if (ack_end)
      begin
         ack_ph_reg <= 1'b0;
         bit_cnt_reg <= '0;
         state_reg <= in_tx ? (ack_seen_reg ? ST_RDATA : ST_IDLE) : nxt_reg;
      end
   end

   always_ff @(posedge link_clk)
   begin
      if (lrst_reg)
      begin
         shift_reg <= '0;
         ack_seen_reg <= 1'b0;
      end
      else if (rise_ev && ack_ph_reg)
         ack_seen_reg <= !sda_f;
      else if (rise_ev && !in_tx && (state_reg != ST_IDLE))
         shift_reg <= {shift_reg[BYTE_MSB-1:0], sda_f};
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // SDA drive: only a low pull or release ever reaches the pin.

   always_ff @(posedge link_clk)
   begin
      if (lrst_reg || trip_f || start_ev || stop_ev)
      begin
         sda_oe_reg <= 1'b0;
         tx_reg <= '0;
      end
      else if (byte_done)
         sda_oe_reg <= !in_tx && ack_ok;
      else if (ack_end)
      begin
         sda_oe_reg <= load_drive && !rd_buf_reg[BYTE_MSB];
         tx_reg <= rd_buf_reg;
      end
      else if (fall_ev && in_tx && !ack_ph_reg)
      begin
         sda_oe_reg <= !tx_reg[BYTE_MSB-1];
         tx_reg <= {tx_reg[BYTE_MSB-1:0], 1'b0};
      end
   end

   always_ff @(posedge link_clk)
   begin
      sda_out_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Address latches.

   always_ff @(posedge link_clk)
   begin
      if (lrst_reg || trip_f)
      begin
         mem_addr_reg <= '0;
         reg_addr_reg <= '0;
         hi_reg <= '0;
         tgt_comp_reg <= 1'b0;
      end
      else if (byte_done)
      begin
         if ((state_reg == ST_DEVADDR) && dev_hit)
            tgt_comp_reg <= id_comp;
         if (state_reg == ST_MEMHI)
            hi_reg <= shift_reg;
         if (state_reg == ST_MEMLO)
            mem_addr_reg <= MEM_AW'({hi_reg, shift_reg});
         if ((state_reg == ST_REGADDR) && reg_ok)
            reg_addr_reg <= shift_reg;
         if (step_ev && !tgt_comp_reg)
            mem_addr_reg <= mem_step;
         if (step_ev && tgt_comp_reg)
            reg_addr_reg <= reg_step;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Crossing to the system clock: one toggle per request, one toggle back per answer.

   always_ff @(posedge link_clk)
   begin
      if (lrst_reg)
      begin
         req_tgl_reg <= 1'b0;
         req_wr_reg <= 1'b0;
         req_comp_reg <= 1'b0;
         req_addr_reg <= '0;
         req_data_reg <= '0;
      end
      else if (wr_fire || rd_fire)
      begin
         req_tgl_reg <= !req_tgl_reg;
         req_wr_reg <= wr_fire;
         req_comp_reg <= use_comp;
         req_addr_reg <= req_addr_next;
         req_data_reg <= shift_reg;
      end
   end

   tws_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync
   (
      .clk(link_clk),
      .rst(lrst_reg),
      .d(ack_tgl),
      .q(ack_q)
   );

   always_ff @(posedge link_clk)
   begin
      if (lrst_reg)
      begin
         ack_old_reg <= 1'b0;
         rd_buf_reg <= '0;
      end
      else if (ack_q != ack_old_reg)
      begin
         ack_old_reg <= ack_q;
         rd_buf_reg <= rd_data;
      end
   end

   tws_store #(.MEM_AW(MEM_AW)) u_store
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .req_tgl(req_tgl_reg),
      .req_wr(req_wr_reg),
      .req_comp(req_comp_reg),
      .req_addr(req_addr_reg),
      .req_data(req_data_reg),
      .comp_rdata(comp_rdata),
      .ack_tgl(ack_tgl),
      .rd_data(rd_data),
      .comp_wr(comp_wr),
      .comp_rd(comp_rd),
      .comp_addr(comp_addr),
      .comp_wdata(comp_wdata)
   );

   assign sda_oe = sda_oe_reg;
   assign sda_out = sda_out_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (lrst_reg);

   a_start_rearm: assert property (
      (start_ev && !trip_f) |=> (state_reg == ST_DEVADDR) && (bit_cnt_reg == '0) && !sda_oe_reg)
      else $error("Start did not rearm the address phase.");
   a_stop_idle: assert property (
      (stop_ev && !trip_f) |=> (state_reg == ST_IDLE) && !sda_oe_reg)
      else $error("Stop did not return to idle.");
   a_trip_abort: assert property (
      trip_f |=> (state_reg == ST_IDLE) && !sda_oe_reg && (mem_addr_reg == '0))
      else $error("Supply trip did not abort.");
   a_low_only: assert property (
      sda_oe_reg |-> !sda_out_reg)
      else $error("SDA driven high.");
   a_ack_drive: assert property (
      (byte_done && !in_tx && ack_ok) |=> sda_oe_reg && ack_ph_reg ##1 sda_oe_reg || !ack_ph_reg)
      else $error("Acknowledge not driven.");
   a_tx_release: assert property (
      (ack_ph_reg && in_tx) |-> !sda_oe_reg)
      else $error("SDA not released in read acknowledge.");
   a_nack_end: assert property (
      (ack_end && in_tx && !ack_seen_reg) |=> (state_reg == ST_IDLE) && !sda_oe_reg)
      else $error("Read not ended on missing acknowledge.");
   a_id_reject: assert property (
      (byte_done && (state_reg == ST_DEVADDR) && !dev_hit) |=> !sda_oe_reg && (nxt_reg == ST_IDLE))
      else $error("Foreign address acknowledged.");
   a_reg_range: assert property (
      (byte_done && (state_reg == ST_REGADDR) && !reg_ok) |=> !sda_oe_reg && $stable(reg_addr_reg))
      else $error("Companion address above range accepted.");
   a_mem_wrap: assert property (
      (step_ev && !tgt_comp_reg) |=> (mem_addr_reg == $past(mem_step)))
      else $error("Memory address did not step.");
   a_comp_keeps: assert property (
      (tgt_comp_reg && (state_reg inside {ST_REGADDR, ST_WDATA, ST_RDATA}) && !trip_f)
      |=> $stable(mem_addr_reg))
      else $error("Companion access moved the memory address.");

endmodule

`default_nettype wire

//--- rtl/tws_pkg.sv
// Shared constants and types of the two-wire dual-target slave.
package tws_pkg;

   localparam logic [3:0] ID_MEM = 4'hA;
   localparam logic [3:0] ID_COMP = 4'hD;
   localparam int ID_HI = 7;
   localparam int ID_LO = 4;
   localparam int SEL_HI = 2;
   localparam int SEL_LO = 1;
   localparam int RW_BIT = 0;
   localparam int BYTE_MSB = 7;
   localparam logic [7:0] REG_LAST = 8'h18;
   localparam logic [7:0] REG_FIRST = 8'h00;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam int MEM_AW_DEF = 9;
   localparam int REQ_AW = 16;

   localparam int PIN_W = 5;
   localparam int PIN_SDA = 0;
   localparam int PIN_SCL = 1;
   localparam int PIN_SEL_LO = 2;
   localparam int PIN_SEL_HI = 3;
   localparam int PIN_TRIP = 4;
   localparam logic [PIN_W-1:0] PIN_RST = 5'h03;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_DEVADDR = 3'h1,
      ST_MEMHI = 3'h3,
      ST_MEMLO = 3'h2,
      ST_WDATA = 3'h6,
      ST_RDATA = 3'h7,
      ST_REGADDR = 3'h5
   } tws_state_t;

endpackage

//--- rtl/tws_sync.sv
// Three-stage input synchroniser that passes a bit once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module tws_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;

   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge clk)
      begin
         if (rst)
         begin
            s1_reg[i] <= RST_VAL[i];
            s2_reg[i] <= RST_VAL[i];
            s3_reg[i] <= RST_VAL[i];
            q_reg[i] <= RST_VAL[i];
         end
         else
         begin
            s1_reg[i] <= d[i];
            s2_reg[i] <= s1_reg[i];
            s3_reg[i] <= s2_reg[i];
            if (s2_reg[i] == s3_reg[i])
               q_reg[i] <= s3_reg[i];
         end
      end
   end

   assign q = q_reg;

endmodule

`default_nettype wire

//--- rtl/tws_store.sv
// Clock-domain responder: memory array and companion register port behind a toggle handshake.
`timescale 1ns/1ps
`default_nettype none

module tws_store
   import tws_pkg::*;
#(
   parameter int MEM_AW = MEM_AW_DEF
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic req_tgl,
   input wire logic req_wr,
   input wire logic req_comp,
   input wire logic [REQ_AW-1:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic [7:0] comp_rdata,
   output logic ack_tgl,
   output logic [7:0] rd_data,
   output logic comp_wr,
   output logic comp_rd,
   output logic [7:0] comp_addr,
   output logic [7:0] comp_wdata
);

   logic req_q;
   logic seen_reg;
   logic pend_reg;
   logic ack_reg;
   logic [7:0] rd_reg;
   logic comp_wr_reg;
   logic comp_rd_reg;
   logic [7:0] comp_addr_reg;
   logic [7:0] comp_wdata_reg;
   logic [7:0] mem_reg [2**MEM_AW];
   logic new_req;
   logic [MEM_AW-1:0] idx;

   tws_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync
   (
      .clk(clock),
      .rst(sys_rst),
      .d(req_tgl),
      .q(req_q)
   );

   // Request fields change on the same edge as the toggle and are steady once it clears the synchroniser, so they are sampled directly.
   assign new_req = req_q != seen_reg;
   assign idx = req_addr[MEM_AW-1:0];

   always_ff @(posedge clock)
   begin
      if (new_req && !req_comp && req_wr)
         mem_reg[idx] <= req_data;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         seen_reg <= 1'b0;
         pend_reg <= 1'b0;
         ack_reg <= 1'b0;
         rd_reg <= '0;
         comp_wr_reg <= 1'b0;
         comp_rd_reg <= 1'b0;
         comp_addr_reg <= '0;
         comp_wdata_reg <= '0;
      end
      else
      begin
         comp_wr_reg <= 1'b0;
         comp_rd_reg <= 1'b0;
         pend_reg <= 1'b0;
         if (new_req)
         begin
            seen_reg <= req_q;
            if (req_comp)
            begin
               comp_addr_reg <= req_addr[7:0];
               comp_wdata_reg <= req_data;
               comp_wr_reg <= req_wr;
               comp_rd_reg <= !req_wr;
               pend_reg <= !req_wr;
               if (req_wr)
                  ack_reg <= !ack_reg;
            end
            else
            begin
               if (!req_wr)
                  rd_reg <= mem_reg[idx];
               ack_reg <= !ack_reg;
            end
         end
         if (pend_reg)
         begin
            rd_reg <= comp_rdata;
            ack_reg <= !ack_reg;
         end
      end
   end

   assign ack_tgl = ack_reg;
   assign rd_data = rd_reg;
   assign comp_wr = comp_wr_reg;
   assign comp_rd = comp_rd_reg;
   assign comp_addr = comp_addr_reg;
   assign comp_wdata = comp_wdata_reg;

endmodule

`default_nettype wire

//--- bench/tws_master.sv
// Two-wire bus master model that makes SCL and pulls SDA low.
`timescale 1ns/1ps
`default_nettype none

module tws_master
#(
   parameter int Q = 700,
   parameter int H = 1100
)
(
   output logic scl,
   output logic pull,
   input wire logic sda
);

   initial
   begin
      scl = 1'b1;
      pull = 1'b0;
   end

   ////////////////////////////////////////

   // Data moves only while SCL is low and is sampled mid-way through the high phase.
   task automatic bit_cyc(input logic b, output logic r);
      pull = ~b;
      #Q;
      scl = 1'b1;
      #(H/2);
      r = sda;
      #(H/2);
      scl = 1'b0;
      #Q;
   endtask

   task automatic start();
      pull = 1'b0;
      #Q;
      scl = 1'b1;
      #H;
      pull = 1'b1;
      #H;
      scl = 1'b0;
      #Q;
   endtask

   task automatic stop();
      pull = 1'b1;
      #Q;
      scl = 1'b1;
      #H;
      pull = 1'b0;
      #H;
   endtask

   task automatic send_bits(input logic [7:0] d, input int n);
      logic r;
      for (int i = 0; i < n; i++)
      begin
         bit_cyc(d[7-i], r);
      end
   endtask

   task automatic write_byte(input logic [7:0] d, output logic ok);
      logic r;
      send_bits(d, 8);
      bit_cyc(1'b1, r);
      ok = ~r;
   endtask

   task automatic read_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_cyc(1'b1, r);
         d[i] = r;
      end
      bit_cyc(~ack, r);
   endtask

endmodule
`default_nettype wire

//--- bench/two_wire_slave_dual_target_tb_top.sv
// Self-checking bench of the two-wire slave driven by the master model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      n_checks++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("wrong value %s expected %0h seen %0h", nm, e, g); \
      end \
   end

module two_wire_slave_dual_target_tb_top
   import tws_pkg::*;
;
   localparam int AW = 9;
   localparam logic [1:0] SEL = 2'h2;
   localparam logic [7:0] MW = {ID_MEM, 1'b0, SEL, 1'b0};
   localparam logic [7:0] MR = MW | 8'h01;
   localparam logic [7:0] CW = {ID_COMP, 1'b0, SEL, 1'b0};
   localparam logic [7:0] CR = CW | 8'h01;
   // Top address with one bit above the array set, which the slave must ignore.
   localparam logic [15:0] TA = 16'((1 << AW) - 1) | 16'h0200;
   logic clock = 1'b0;
   logic link_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic supply_low = 1'b0;
   logic scl, pull, sda_out, sda_oe, comp_wr, comp_rd;
   logic [7:0] comp_addr, comp_wdata, comp_rdata, wr_addr, wr_data;
   wire sda;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   int wr_cnt = 0;
   int rd_cnt = 0;
   logic [1:0] sel = SEL;

   always #5 clock = ~clock;
   initial
   begin
      #3.3;
      forever #62.5 link_clk = ~link_clk;
   end

   // The wire is pulled up and low whenever either party pulls it.
   assign sda = ~((sda_oe & ~sda_out) | pull);
   assign comp_rdata = comp_addr ^ 8'hA5;

   tws_slave #(.MEM_AW(AW)) tws_slave_i (.clock(clock), .sys_rst(sys_rst),
      .link_clk(link_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .sel_pins(sel), .supply_low(supply_low), .comp_rdata(comp_rdata), .comp_wr(comp_wr),
      .comp_rd(comp_rd), .comp_addr(comp_addr), .comp_wdata(comp_wdata));
   tws_master tws_master_i (.scl(scl), .pull(pull), .sda(sda));

   ////////////////////////////////////////

   task automatic final_report();
      if (errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cycles++;
      if (comp_wr === 1'b1)
      begin
         wr_cnt++;
         wr_addr = comp_addr;
         wr_data = comp_wdata;
      end
      if (comp_rd === 1'b1)
         rd_cnt++;
      if (cycles == 99000)
      begin
         errors++;
         final_report();
      end
   end

   task automatic wr(input logic [7:0] d, input logic exp);
      logic ok;
      tws_master_i.write_byte(d, ok);
      `CHK("ack", exp, ok)
   endtask

   task automatic rd(input logic ack, input logic [7:0] exp);
      logic [7:0] d;
      tws_master_i.read_byte(ack, d);
      `CHK("read data", exp, d)
   endtask

   task automatic t_mem_write();
      tws_master_i.start();
      wr(MW, 1'b1);
      wr(TA[15:8], 1'b1);
      wr(TA[7:0], 1'b1);
      wr(8'h3C, 1'b1);
      wr(8'hC3, 1'b1);
      wr(8'h5A, 1'b1);
      tws_master_i.stop();
   endtask

   task automatic t_random_read();
      tws_master_i.start();
      wr(MW, 1'b1);
      wr(TA[15:8], 1'b1);
      wr(TA[7:0], 1'b1);
      tws_master_i.start();
      wr(MR, 1'b1);
      rd(1'b1, 8'h3C);
      rd(1'b0, 8'hC3);
      repeat (50) @(posedge clock);
      #1;
      `CHK("sda_oe", 1'b0, sda_oe)
      `CHK("sda_out", 1'b0, sda_out)
      tws_master_i.stop();
   endtask

   task automatic t_companion();
      int wr0;
      int rd0;
      wr0 = wr_cnt;
      rd0 = rd_cnt;
      tws_master_i.start();
      wr(CW, 1'b1);
      wr(8'h17, 1'b1);
      wr(8'h11, 1'b1);
      wr(8'h22, 1'b1);
      tws_master_i.stop();
      `CHK("companion writes", wr0 + 2, wr_cnt)
      `CHK("companion address", 8'h18, wr_addr)
      `CHK("companion data", 8'h22, wr_data)
      tws_master_i.start();
      wr(CR, 1'b1);
      rd(1'b0, 8'hA5);
      tws_master_i.stop();
      `CHK("companion reads", rd0 + 2, rd_cnt)
      tws_master_i.start();
      wr(MR, 1'b1);
      rd(1'b0, 8'h5A);
      tws_master_i.stop();
   endtask

   task automatic t_refuse();
      int wr0;
      wr0 = wr_cnt;
      tws_master_i.start();
      wr({ID_MEM, 1'b0, ~SEL, 1'b0}, 1'b0);
      tws_master_i.stop();
      tws_master_i.start();
      wr(8'hB4, 1'b0);
      tws_master_i.stop();
      tws_master_i.start();
      wr(CW, 1'b1);
      wr(8'h19, 1'b0);
      tws_master_i.stop();
      `CHK("companion writes", wr0, wr_cnt)
      sel = ~SEL;
      tws_master_i.start();
      wr({ID_MEM, 1'b0, ~SEL, 1'b0}, 1'b1);
      tws_master_i.stop();
      sel = SEL;
   endtask

   task automatic t_abort();
      tws_master_i.start();
      wr(MW, 1'b1);
      wr(8'h00, 1'b1);
      wr(8'h01, 1'b1);
      tws_master_i.send_bits(8'hFF, 4);
      tws_master_i.start();
      wr(MR, 1'b1);
      rd(1'b0, 8'h5A);
      tws_master_i.stop();
   endtask

   task automatic t_supply();
      tws_master_i.start();
      wr(MW, 1'b1);
      wr(8'h00, 1'b1);
      supply_low = 1'b1;
      repeat (100) @(posedge clock);
      #1;
      wr(8'h01, 1'b0);
      supply_low = 1'b0;
      repeat (100) @(posedge clock);
      #1;
      wr(8'h01, 1'b0);
      tws_master_i.stop();
      tws_master_i.start();
      wr(MR, 1'b1);
      rd(1'b0, 8'hC3);
      tws_master_i.stop();
   endtask

   initial
   begin
      repeat (5) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      repeat (100) @(posedge clock);
      #1;
      t_mem_write();
      t_random_read();
      t_companion();
      t_refuse();
      t_abort();
      t_supply();
      final_report();
   end

endmodule
`default_nettype wire
